// [sia_defs.svh]
/*
  Offsets, field positions, reset values and fixed codes for the shared
  indirect access and self-test register group.
  Assumes an 8-bit register address space behind the serial control bus.
*/
`ifndef SIA_DEFS_SVH
`define SIA_DEFS_SVH

// register offsets
`define SIA_OFS_IND_CTL 8'hb0
`define SIA_OFS_IND_OFFSET 8'hb1
`define SIA_OFS_IND_DATA 8'hb2
`define SIA_OFS_ST_CTL 8'hb3
`define SIA_OFS_STRAP_STS 8'hb8

// indirect control fields
`define SIA_IND_SEL_MSB 5
`define SIA_IND_SEL_LSB 2
`define SIA_IND_AUTO_INC_BIT 1
`define SIA_IND_READ_BIT 0

// indirect target codes
`define SIA_SEL_PORT0 4'h1
`define SIA_SEL_PORT1 4'h2
`define SIA_SEL_SHARED 4'h5
`define SIA_SEL_BOTH 4'h6

// self-test control fields
`define SIA_ST_MODE_MSB 7
`define SIA_ST_MODE_LSB 6
`define SIA_ST_SRC_BIT 3
`define SIA_ST_CLK_MSB 2
`define SIA_ST_CLK_LSB 1
`define SIA_ST_EN_BIT 0

// strap status fields
`define SIA_STS_INDEX_DECODE_DONE_BIT 7
`define SIA_STS_IDX_MSB 6
`define SIA_STS_IDX_LSB 4
`define SIA_STS_MODE_DONE_BIT 3
`define SIA_STS_MODE_MSB 2
`define SIA_STS_MODE_LSB 0

// reset values
`define SIA_RST_IND_SEL 4'h0
`define SIA_RST_OFFSET 8'h00
`define SIA_RST_DATA 8'h00
`define SIA_RST_ST_MODE 2'h0
`define SIA_RST_ST_SRC 1'h1
`define SIA_RST_ST_CLK 2'h0
`define SIA_RST_ST_EN 1'h0

// remote serializer clock source register
`define SIA_RMT_CLK_OFS 8'h14

// strap settle time in ns, and its cycle count at 100 MHz (least time, rounded up)
`define SIA_STRAP_SETTLE_NS 100
`define SIA_CLK_PERIOD_NS 10
`define SIA_STRAP_SETTLE_CYC \
    ((`SIA_STRAP_SETTLE_NS + `SIA_CLK_PERIOD_NS - 1) / `SIA_CLK_PERIOD_NS)

`endif

// [sia_pkg.sv]
/*
  Types shared by the indirect access and self-test register group.
  Assumes sia_defs.svh supplies all numeric constants.
*/
`default_nettype none
package sia_pkg;

    // one indirect access toward the per-port or shared register blocks
    typedef struct packed {
        logic wr;          // one-cycle write strobe
        logic rd;          // one-cycle read (prefetch) strobe
        logic to_port0;
        logic to_port1;
        logic to_shared;
        logic [7:0] offset;
        logic [7:0] wdata;
    } sia_ind_req_t;

    // write request toward the remote serializer
    typedef struct packed {
        logic wr;
        logic [7:0] offset;
        logic [7:0] wdata;
    } sia_rmt_req_t;

    // effective self-test configuration
    typedef struct packed {
        logic enable;
        logic [1:0] out_mode;
        logic [1:0] clk_sel;
    } sia_st_cfg_t;

    typedef enum logic [1:0] {
        SIA_MODE_STATIC,
        SIA_MODE_ALTERNATE,
        SIA_MODE_DATA_A,
        SIA_MODE_DATA_B
    } sia_out_mode_t;

endpackage : sia_pkg
`default_nettype wire

// [sia_regs.sv]
/*
  Shared register group: indirect access window into the per-port and
  shared register blocks, self-test control and strap decode status.
  Assumes a serial control bus slave outside that presents one-cycle
  register read and write strobes with an 8-bit address, and target
  blocks that return read data combinationally for the live offset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sia_defs.svh"

// Summary of operation
// - target code 1 port 0, 2 port 1, 5 shared, 6 both ports; others reserved.
// - read bit set: writing the offset register issues a prefetch read strobe.
// - auto-increment and read set: data register read strobes again after advancing.
// - offset register holds an 8-bit offset inside the chosen target block.
// - writing the data register writes that value to the target at the offset.
// - reading the data register returns the target register at the offset.
// - output mode 00 static, 01 alternate one/zero, 1x follows self-test data.
// - config source bit resets to one; one uses strap pins, zero register bits.
// - on self-test enable, write clock select to remote offset 0x14.
// - index done flag reads one once the index strap is latched.
// - index strap decode reads in status bits 6 to 4.
// - mode done in bit 3, mode strap decode in bits 2 to 0.
module sia_regs #(
    parameter int unsigned SETTLE_CYC = `SIA_STRAP_SETTLE_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    // register port from the serial control bus slave
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_valid,
    output logic reg_hit,
    // indirect access toward target blocks
    output sia_pkg::sia_ind_req_t ind_req,
    output logic [7:0] ind_live_offset,
    input wire logic [7:0] ind_rdata_port0,
    input wire logic [7:0] ind_rdata_port1,
    input wire logic [7:0] ind_rdata_shared,
    // self-test
    input wire logic [2:0] st_pin_cfg,
    input wire logic st_data,
    output sia_pkg::sia_st_cfg_t st_cfg,
    output logic st_toggle_out,
    output sia_pkg::sia_rmt_req_t rmt_req,
    // straps
    input wire logic [2:0] idx_strap_level,
    input wire logic [2:0] mode_strap_level
);

    logic [3:0] sel_r;
    logic auto_inc_r;
    logic read_pf_r;
    logic [7:0] offset_r;
    logic [1:0] st_mode_r;
    logic st_src_r;
    logic [1:0] st_clk_r;
    logic st_en_r;
    logic st_en_eff_d_r;
    logic toggle_r;
    logic [2:0] idx_value;
    logic index_decode_done;
    logic [2:0] mode_value;
    logic mode_done;
    logic wr_ctl, wr_ofs, wr_data, wr_st, rd_data;
    logic sel_p0, sel_p1, sel_sh;
    logic [7:0] tgt_rdata;
    logic [7:0] rdata_nxt;
    logic hit_nxt;
    sia_pkg::sia_st_cfg_t cfg_nxt;

    // address decode of the strobes
    assign wr_ctl = reg_wr && (reg_addr == `SIA_OFS_IND_CTL);
    assign wr_ofs = reg_wr && (reg_addr == `SIA_OFS_IND_OFFSET);
    assign wr_data = reg_wr && (reg_addr == `SIA_OFS_IND_DATA);
    assign wr_st = reg_wr && (reg_addr == `SIA_OFS_ST_CTL);
    assign rd_data = reg_rd && (reg_addr == `SIA_OFS_IND_DATA);

    // target routing; reserved codes reach no block
    assign sel_p0 = (sel_r == `SIA_SEL_PORT0) || (sel_r == `SIA_SEL_BOTH);
    assign sel_p1 = (sel_r == `SIA_SEL_PORT1) || (sel_r == `SIA_SEL_BOTH);
    assign sel_sh = (sel_r == `SIA_SEL_SHARED);
    assign ind_live_offset = offset_r;

    // read data from the selected block; both-port code is write-only, reads zero
    always_comb begin
        if (sel_r == `SIA_SEL_PORT0) begin
            tgt_rdata = ind_rdata_port0;
        end else if (sel_r == `SIA_SEL_PORT1) begin
            tgt_rdata = ind_rdata_port1;
        end else if (sel_r == `SIA_SEL_SHARED) begin
            tgt_rdata = ind_rdata_shared;
        end else begin
            tgt_rdata = 8'h00;
        end
    end

    // indirect control register; bits 7:6 are not stored
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_r <= `SIA_RST_IND_SEL;
            auto_inc_r <= 1'b0;
            read_pf_r <= 1'b0;
        end else if (wr_ctl) begin
            sel_r <= reg_wdata[`SIA_IND_SEL_MSB:`SIA_IND_SEL_LSB];
            auto_inc_r <= reg_wdata[`SIA_IND_AUTO_INC_BIT];
            read_pf_r <= reg_wdata[`SIA_IND_READ_BIT];
        end
    end

    // offset register; a direct write beats a same-cycle increment
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            offset_r <= `SIA_RST_OFFSET;
        end else if (wr_ofs) begin
            offset_r <= reg_wdata;
        end else if (auto_inc_r && (wr_data || rd_data)) begin
            offset_r <= offset_r + 8'h01;
        end
    end

    // indirect strobes, one cycle after the host access; the offset carried
    // is the one in effect when the strobe is due
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ind_req <= '0;
        end else begin
            ind_req.wr <= wr_data && (sel_p0 || sel_p1 || sel_sh);
            ind_req.rd <= (wr_ofs && read_pf_r)
                || (rd_data && read_pf_r && auto_inc_r);
            ind_req.to_port0 <= sel_p0;
            ind_req.to_port1 <= sel_p1;
            ind_req.to_shared <= sel_sh;
            if (wr_data) begin
                ind_req.offset <= offset_r;
                ind_req.wdata <= reg_wdata;
            end else if (wr_ofs) begin
                ind_req.offset <= reg_wdata;
            end else if (rd_data) begin
                ind_req.offset <= offset_r + 8'h01;
            end
        end
    end

    // self-test control register; bits 5:4 are not stored
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_mode_r <= `SIA_RST_ST_MODE;
            st_src_r <= `SIA_RST_ST_SRC;
            st_clk_r <= `SIA_RST_ST_CLK;
            st_en_r <= `SIA_RST_ST_EN;
        end else if (wr_st) begin
            st_mode_r <= reg_wdata[`SIA_ST_MODE_MSB:`SIA_ST_MODE_LSB];
            st_src_r <= reg_wdata[`SIA_ST_SRC_BIT];
            st_clk_r <= reg_wdata[`SIA_ST_CLK_MSB:`SIA_ST_CLK_LSB];
            st_en_r <= reg_wdata[`SIA_ST_EN_BIT];
        end
    end

    // effective configuration: strap pins or the low register bits
    always_comb begin
        cfg_nxt.out_mode = st_mode_r;
        if (st_src_r) begin
            cfg_nxt.enable = st_pin_cfg[`SIA_ST_EN_BIT];
            cfg_nxt.clk_sel = st_pin_cfg[`SIA_ST_CLK_MSB:`SIA_ST_CLK_LSB];
        end else begin
            cfg_nxt.enable = st_en_r;
            cfg_nxt.clk_sel = st_clk_r;
        end
    end

    // registered config and remote write on each enable rising edge
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_cfg <= '0;
            st_en_eff_d_r <= 1'b0;
            rmt_req <= '0;
        end else begin
            st_cfg <= cfg_nxt;
            st_en_eff_d_r <= cfg_nxt.enable;
            rmt_req.wr <= cfg_nxt.enable && !st_en_eff_d_r;
            rmt_req.offset <= `SIA_RMT_CLK_OFS;
            rmt_req.wdata <= {6'h00, cfg_nxt.clk_sel};
        end
    end

    // output pattern; held low while self-test is off
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            toggle_r <= 1'b0;
        end else if (!st_cfg.enable) begin
            toggle_r <= 1'b0;
        end else begin
            case (sia_pkg::sia_out_mode_t'(st_cfg.out_mode))
                sia_pkg::SIA_MODE_STATIC: toggle_r <= toggle_r;
                sia_pkg::SIA_MODE_ALTERNATE: toggle_r <= !toggle_r;
                default: toggle_r <= st_data;
            endcase
        end
    end
    assign st_toggle_out = toggle_r;

    // strap decoders for the index and mode pins
    sia_strap_decode #(
        .SETTLE_CYC(SETTLE_CYC)
    ) u_idx_strap (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .strap_level(idx_strap_level),
        .strap_value(idx_value),
        .decode_done(index_decode_done)
    );

    sia_strap_decode #(
        .SETTLE_CYC(SETTLE_CYC)
    ) u_mode_strap (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .strap_level(mode_strap_level),
        .strap_value(mode_value),
        .decode_done(mode_done)
    );

    // read mux; reserved bits and unmapped offsets read zero
    always_comb begin
        rdata_nxt = 8'h00;
        hit_nxt = 1'b1;
        if (reg_addr == `SIA_OFS_IND_CTL) begin
            rdata_nxt = {2'h0, sel_r, auto_inc_r, read_pf_r};
        end else if (reg_addr == `SIA_OFS_IND_OFFSET) begin
            rdata_nxt = offset_r;
        end else if (reg_addr == `SIA_OFS_IND_DATA) begin
            rdata_nxt = tgt_rdata;
        end else if (reg_addr == `SIA_OFS_ST_CTL) begin
            rdata_nxt = {st_mode_r, 2'h0, st_src_r, st_clk_r, st_en_r};
        end else if (reg_addr == `SIA_OFS_STRAP_STS) begin
            rdata_nxt = {index_decode_done, idx_value,
                mode_done, mode_value};
        end else begin
            hit_nxt = 1'b0;
        end
    end

    // read data register, valid one cycle after the read strobe
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
            reg_rdata_valid <= 1'b0;
            reg_hit <= 1'b0;
        end else begin
            reg_rdata_valid <= reg_rd;
            if (reg_rd || reg_wr) begin
                reg_hit <= hit_nxt;
            end
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

endmodule : sia_regs
`default_nettype wire

// [sia_regs_properties.sv]
/* port-level assertions for the shared register group.
   assumes one clock domain and straps held steady after reset */
`timescale 1ns/1ps
`default_nettype none
module sia_regs_properties #(
    parameter int unsigned SETTLE_CYC = 10
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rdata_valid,
    input wire logic reg_hit,
    input wire sia_pkg::sia_ind_req_t ind_req,
    input wire logic [7:0] ind_live_offset,
    input wire logic [7:0] ind_rdata_port0,
    input wire logic [7:0] ind_rdata_port1,
    input wire logic [7:0] ind_rdata_shared,
    input wire logic [2:0] st_pin_cfg,
    input wire logic st_data,
    input wire sia_pkg::sia_st_cfg_t st_cfg,
    input wire logic st_toggle_out,
    input wire sia_pkg::sia_rmt_req_t rmt_req,
    input wire logic [2:0] idx_strap_level,
    input wire logic [2:0] mode_strap_level
);
    logic ainc_r;
    logic pref_r;
    logic [3:0] age_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // shadow of the control bits, needed to know what each access should do
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ainc_r <= 1'b0;
            pref_r <= 1'b0;
        end else if (reg_wr && reg_addr == 8'hb0) begin
            ainc_r <= reg_wdata[1];
            pref_r <= reg_wdata[0];
        end
    end
    // saturating age so the strap latch is known to be done
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            age_r <= 4'h0;
        else if (age_r != 4'hf)
            age_r <= age_r + 4'h1;
    end
    sequence s_alt;
        (st_cfg.enable && st_cfg.out_mode == 2'h1) [*3];
    endsequence
    sequence s_static;
        (st_cfg.enable && st_cfg.out_mode == 2'h0) [*3];
    endsequence
    AST_VALID: assert property (reg_rd |=> reg_rdata_valid)
        else $error("read valid missing");
    AST_SEL: assert property (
        ind_req.wr |-> (ind_req.to_port0 || ind_req.to_port1 || ind_req.to_shared)
            && !(ind_req.to_shared && ind_req.to_port0))
        else $error("write strobe with bad target");
    AST_INC: assert property (
        reg_wr && reg_addr == 8'hb2 && ainc_r
            |=> ind_live_offset == $past(ind_live_offset) + 8'h01)
        else $error("offset did not advance");
    AST_PREF: assert property (
        reg_wr && reg_addr == 8'hb1 && pref_r
            |=> ind_req.rd && ind_req.offset == $past(reg_wdata))
        else $error("no prefetch on offset write");
    AST_RDINC: assert property (
        reg_rd && reg_addr == 8'hb2 && ainc_r && pref_r
            |=> ind_req.rd && ind_req.offset == $past(ind_live_offset) + 8'h01)
        else $error("no prefetch after data read");
    AST_OFS: assert property (
        reg_wr && reg_addr == 8'hb1 |=> ind_live_offset == $past(reg_wdata))
        else $error("offset not loaded");
    AST_WR: assert property (
        reg_wr && reg_addr == 8'hb2
            |=> ind_req.wdata == $past(reg_wdata) && ind_req.offset == $past(ind_live_offset))
        else $error("indirect write wrong");
    AST_RD: assert property (
        reg_rd && reg_addr == 8'hb2 && ind_req.to_shared
            |=> reg_rdata == $past(ind_rdata_shared))
        else $error("indirect read wrong");
    AST_ALT: assert property (s_alt |-> st_toggle_out != $past(st_toggle_out))
        else $error("alternate mode not toggling");
    // static mode holds whatever level the output had, it does not force low
    AST_STATIC: assert property (s_static |-> st_toggle_out == $past(st_toggle_out))
        else $error("static mode toggling");
    AST_RMT: assert property (
        $rose(st_cfg.enable) |-> ##[0:1] (rmt_req.wr && rmt_req.offset == 8'h14
            && rmt_req.wdata == {6'h00, st_cfg.clk_sel}))
        else $error("remote clock write missing");
    AST_DONE: assert property (
        reg_rd && reg_addr == 8'hb8 && age_r > SETTLE_CYC + 1
            |=> reg_rdata[7] && reg_rdata[3])
        else $error("decode done flags low");
    AST_RSV: assert property (reg_rd && reg_addr == 8'hb3 |=> reg_rdata[5:4] == 2'h0)
        else $error("reserved bits not zero");
endmodule : sia_regs_properties
bind sia_regs sia_regs_properties #(.SETTLE_CYC(SETTLE_CYC)) u_sia_regs_properties (
    .core_clk(core_clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .reg_hit(reg_hit), .ind_req(ind_req),
    .ind_live_offset(ind_live_offset), .ind_rdata_port0(ind_rdata_port0),
    .ind_rdata_port1(ind_rdata_port1), .ind_rdata_shared(ind_rdata_shared),
    .st_pin_cfg(st_pin_cfg), .st_data(st_data), .st_cfg(st_cfg),
    .st_toggle_out(st_toggle_out), .rmt_req(rmt_req),
    .idx_strap_level(idx_strap_level), .mode_strap_level(mode_strap_level));
`default_nettype wire

// [sia_strap_decode.sv]
/*
  Latches one 3-bit strap value once it has settled after reset and
  raises a done flag. Assumes the strap level is synchronous to the clock
  and stable for the settle time after reset release.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sia_defs.svh"

module sia_strap_decode #(
    parameter int unsigned SETTLE_CYC = `SIA_STRAP_SETTLE_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [2:0] strap_level,
    output logic [2:0] strap_value,
    output logic decode_done
);

    logic [7:0] settle_cnt_r;

    // count settle cycles, then latch the strap once and hold it
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            settle_cnt_r <= 8'h00;
            strap_value <= 3'h0;
            decode_done <= 1'b0;
        end else if (!decode_done) begin
            if (settle_cnt_r >= 8'(SETTLE_CYC)) begin
                strap_value <= strap_level;
                decode_done <= 1'b1;
            end else begin
                settle_cnt_r <= settle_cnt_r + 8'h01;
            end
        end
    end

endmodule : sia_strap_decode
`default_nettype wire

// [sia_target_model.sv]
/* target register blocks behind the indirect window: port 0, port 1, shared.
   assumes the window's registered strobes and combinational read-back */
`timescale 1ns/1ps
`default_nettype none
module sia_target_model (
    input wire logic core_clk,
    input wire sia_pkg::sia_ind_req_t ind_req,
    input wire logic [7:0] ind_live_offset,
    output logic [7:0] rdata_port0,
    output logic [7:0] rdata_port1,
    output logic [7:0] rdata_shared
);
    logic [7:0] p0_mem [256];
    logic [7:0] p1_mem [256];
    logic [7:0] sh_mem [256];
    // start blank so untouched places read zero
    initial begin
        foreach (p0_mem[i]) begin
            p0_mem[i] = 8'h00;
            p1_mem[i] = 8'h00;
            sh_mem[i] = 8'h00;
        end
    end
    // a write lands in every flagged block in the same cycle
    always @(posedge core_clk) begin
        if (ind_req.wr && ind_req.to_port0)
            p0_mem[ind_req.offset] <= ind_req.wdata;
        if (ind_req.wr && ind_req.to_port1)
            p1_mem[ind_req.offset] <= ind_req.wdata;
        if (ind_req.wr && ind_req.to_shared)
            sh_mem[ind_req.offset] <= ind_req.wdata;
    end
    // read data follows the live offset with no delay
    assign rdata_port0 = p0_mem[ind_live_offset];
    assign rdata_port1 = p1_mem[ind_live_offset];
    assign rdata_shared = sh_mem[ind_live_offset];
endmodule : sia_target_model
`default_nettype wire

// [tb_sia_regs.sv]
/* self-checking bench for the shared register group: reset values,
   indirect window, self-test and strap status. assumes the target model */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, ind_live_offset, rd_p0, rd_p1, rd_sh, got, rmt_data, win_exp;
    logic reg_rdata_valid, reg_hit, st_toggle_out;
    logic [2:0] st_pin_cfg = 3'h0;
    logic st_data = 1'b0;
    sia_pkg::sia_ind_req_t ind_req;
    sia_pkg::sia_st_cfg_t st_cfg;
    sia_pkg::sia_rmt_req_t rmt_req;
    int rmt_cnt = 0;
    int failures = 0;
    int num_checks = 0;
    logic [7:0] ra [6] = '{8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb8, 8'hb4};
    logic [7:0] re [6] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'hdb, 8'h00};
    always #5 core_clk = ~core_clk;
    // small settle count keeps the strap wait short
    sia_regs #(.SETTLE_CYC(2)) u_sia_regs (.core_clk(core_clk), .reset_n(reset_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid), .reg_hit(reg_hit),
        .ind_req(ind_req), .ind_live_offset(ind_live_offset), .ind_rdata_port0(rd_p0),
        .ind_rdata_port1(rd_p1), .ind_rdata_shared(rd_sh), .st_pin_cfg(st_pin_cfg),
        .st_data(st_data), .st_cfg(st_cfg), .st_toggle_out(st_toggle_out),
        .rmt_req(rmt_req), .idx_strap_level(3'h5), .mode_strap_level(3'h3));
    sia_target_model u_sia_target_model (.core_clk(core_clk), .ind_req(ind_req),
        .ind_live_offset(ind_live_offset), .rdata_port0(rd_p0), .rdata_port1(rd_p1),
        .rdata_shared(rd_sh));
    // count remote writes, no acknowledge comes back
    always @(posedge core_clk) begin
        if (rmt_req.wr === 1'b1) begin
            rmt_cnt <= rmt_cnt + 1;
            rmt_data <= rmt_req.wdata;
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // one-cycle strobe, data taken once the edge's updates have landed
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        got = reg_rdata;
        chk("read valid", 8'h01, {7'h00, reg_rdata_valid});
    endtask : rd
    task automatic print_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // cut a hang short well past the expected run of about 160 cycles
    initial begin
        #100us;
        failures++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        settle(6);
        for (int i = 0; i < 6; i++) begin
            rd(ra[i]);
            chk("reset read", re[i], got);
            chk("mapped hit", (i < 5) ? 8'h01 : 8'h00, {7'h00, reg_hit});
        end
        chk("unmapped hit", 8'h00, {7'h00, reg_hit});
        // target codes 0 to 7, reserved ones and the both-port code must read back zero
        for (int s = 0; s < 8; s++) begin
            wr(8'hb0, 8'(s << 2));
            wr(8'hb1, 8'h10 + 8'(s));
            wr(8'hb2, 8'ha0 + 8'(s));
            rd(8'hb2);
            win_exp = (s == 1 || s == 2 || s == 5) ? 8'ha0 + 8'(s) : 8'h00;
            chk("window", win_exp, got);
        end
        chk("both p0", 8'ha6, u_sia_target_model.p0_mem[8'h16]);
        chk("both p1", 8'ha6, u_sia_target_model.p1_mem[8'h16]);
        chk("reserved", 8'h00, u_sia_target_model.p0_mem[8'h13]);
        // shared target with auto-increment and prefetch, back to back
        wr(8'hb0, 8'h17);
        wr(8'hb1, 8'h20);
        for (int i = 0; i < 3; i++)
            wr(8'hb2, 8'h31 + 8'(i));
        wr(8'hb1, 8'h20);
        for (int i = 0; i < 3; i++) begin
            rd(8'hb2);
            chk("auto read", 8'h31 + 8'(i), got);
        end
        rd(8'hb1);
        chk("offset", 8'h23, got);
        wr(8'hb1, 8'hff);
        wr(8'hb2, 8'h5a);
        rd(8'hb1);
        chk("offset wrap", 8'h00, got);
        chk("wrap data", 8'h5a, u_sia_target_model.sh_mem[8'hff]);
        // clock select 2 only: setting 3 is unsafe with older serializers
        wr(8'hb3, 8'h75);
        settle(4);
        chk("remote count", 8'h01, 8'(rmt_cnt));
        chk("remote data", 8'h02, rmt_data);
        rd(8'hb3);
        chk("selftest ctl", 8'h45, got);
        wr(8'hb3, 8'h85);
        st_data <= 1'b1;
        settle(4);
        chk("data mode", 8'h01, {7'h00, st_toggle_out});
        chk("out mode", 8'h02, {6'h00, st_cfg.out_mode});
        // static holds the last level; data input changes once the mode has landed
        wr(8'hb3, 8'h05);
        repeat (4) @(posedge core_clk);
        st_data <= 1'b0;
        settle(4);
        chk("static mode", 8'h01, {7'h00, st_toggle_out});
        wr(8'hb3, 8'hc5);
        settle(4);
        chk("data mode b", 8'h00, {7'h00, st_toggle_out});
        wr(8'hb3, 8'h00);
        settle(2);
        chk("enable off", 8'h00, {7'h00, st_cfg.enable});
        @(posedge core_clk);
        st_pin_cfg <= 3'h3;
        wr(8'hb3, 8'h08);
        settle(4);
        chk("pin enable", 8'h01, {7'h00, st_cfg.enable});
        chk("pin clock", 8'h01, {6'h00, st_cfg.clk_sel});
        chk("remote count", 8'h02, 8'(rmt_cnt));
        chk("pin remote data", 8'h01, rmt_data);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
